// ---- design/src_pkg.sv ----
/*
 * package for the sleep and reset controller: register map, field positions,
 * reset values, timing counts and carrier types.
 * assumes a 40 MHz APB clock and a single clock domain.
 */
package src_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SLEEP_CTRL_OFF   = 8'h00;
    localparam logic [7:0] RESET_STATUS_OFF = 8'h04;
    localparam logic [7:0] RESET_CTRL_OFF   = 8'h08;
    localparam logic [7:0] POWER_RED_OFF    = 8'h0C;
    localparam logic [7:0] STATE_OFF        = 8'h10;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int SLEEP_EN_BIT   = 0;
    localparam int SLEEP_MODE_LSB = 1;
    localparam int SW_RESET_BIT   = 0;
    localparam int BOOT_VEC_BIT   = 1;
    localparam int NUM_PERIPH     = 8;
    localparam logic [3:0] SLEEP_CTRL_RST = 4'h0;
    localparam logic [7:0] POWER_RED_RST  = 8'h00;

    // reset status bit order
    localparam int RS_POR  = 0;
    localparam int RS_EXT  = 1;
    localparam int RS_BOD  = 2;
    localparam int RS_WDOG = 3;
    localparam int RS_DBG  = 4;
    localparam int RS_SW   = 5;
    localparam int NUM_RS  = 6;

    localparam logic [17:0] RESET_VECTOR_APP  = 18'h00000;
    localparam logic [17:0] BOOT_VECTOR_DFLT  = 18'h08000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 40;
    localparam int WAKE_HALT_CYC    = 4;
    localparam int RST_DELAY_US     = 64;
    localparam int RST_DELAY_CYC    = RST_DELAY_US * CLK_MHZ;
    localparam int OSC_START_US     = 10;
    localparam int OSC_START_CYC    = OSC_START_US * CLK_MHZ;
    localparam int OSC_CAL_US       = 20;
    localparam int OSC_CAL_CYC      = OSC_CAL_US * CLK_MHZ;
    localparam int SW_RESET_LAT_CYC = 2;
    localparam int OSC2M_KHZ        = 2000;
    localparam int OSC2M_DIV        = CLK_MHZ * 1000 / OSC2M_KHZ;
    localparam int CNT_W            = 13;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SM_IDLE, SM_PDOWN, SM_PSAVE, SM_RSVD3, SM_RSVD4, SM_RSVD5, SM_STDBY, SM_ESTDBY
    } src_sleep_mode_type;

    typedef enum logic [1:0] { CS_INTOSC2M, CS_INTOSC32M, CS_XOSC, CS_PLL } src_clk_sel_type;

    typedef struct packed {
        logic por;
        logic ext_n;
        logic brownout_detector;
        logic watchdog_timer;
        logic program_debug_iface;
    } src_rst_src_type;

    typedef struct packed {
        logic any_irq;
        logic twi_match;
        logic port_async;
        logic usb_resume;
        logic rtc;
    } src_wake_type;

    typedef struct packed {
        logic cpu_clk_en;
        logic nvm_clk_en;
        logic periph_clk_en;
        logic rtc_clk_en;
        logic sysosc_en;
    } src_clk_gate_type;

endpackage : src_pkg

// ---- design/src_sleep_reset_ctrl.sv ----
/*
 * sleep and reset controller: sleep state selection, wake-up sequencing,
 * clock gating, power reduction and reset entry/release sequencing.
 * assumes an apb master on pclk; reset sources arrive asynchronously.
 */
`timescale 1ns/100ps
module src_sleep_reset_ctrl (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire src_pkg::src_rst_src_type rst_src,
    input  wire logic                     chip_erase,
    input  wire logic                     brownout_en_cfg,
    input  wire logic                     sleep_instr,
    input  wire src_pkg::src_wake_type    wake_src,
    output src_pkg::src_clk_gate_type     clk_gate,
    output logic [7:0]                    periph_clk_en,
    output logic                          cpu_halt,
    output logic                          sys_rst_n,
    output logic                          io_tristate,
    output logic [17:0]                   reset_vector,
    output src_pkg::src_clk_sel_type      clk_sel,
    output logic                          brownout_force_low
);
    import src_pkg::*;

    // ------------------------------------------------------------
    // synchronisers and reset request combination
    // ------------------------------------------------------------
    logic [4:0] src_meta_reg, src_sync_reg;
    logic [4:0] wake_meta_reg, wake_sync_reg;
    logic       sw_rst_pend_reg, sw_rst_pend_next;
    logic       sw_rst_req_reg, sw_rst_req_next;
    logic       hw_req;
    logic       any_req;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_meta_reg  <= 5'h01;
            src_sync_reg  <= 5'h01;
            wake_meta_reg <= 5'h00;
            wake_sync_reg <= 5'h00;
        end else begin
            src_meta_reg  <= {rst_src.program_debug_iface, rst_src.watchdog_timer,
                              rst_src.brownout_detector, ~rst_src.ext_n, rst_src.por};
            src_sync_reg  <= src_meta_reg;
            wake_meta_reg <= wake_src;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // source levels only after two flops; presetn alone acts without a clock
    assign hw_req  = |src_sync_reg;
    assign any_req = hw_req | sw_rst_req_reg;

    // ------------------------------------------------------------
    // reset release sequencer
    // ------------------------------------------------------------
    typedef enum { RQ_HOLD, RQ_DELAY, RQ_OSCSTART, RQ_OSCCAL, RQ_RUN } src_rst_state_type;
    src_rst_state_type rst_state_reg, rst_state_next;
    logic [CNT_W-1:0]  rst_cnt_reg, rst_cnt_next;

    always_comb begin
        rst_state_next = rst_state_reg;
        rst_cnt_next   = rst_cnt_reg;
        if (any_req) begin
            rst_state_next = RQ_HOLD;
            rst_cnt_next   = '0;
        end else begin
            unique case (rst_state_reg)
                RQ_HOLD: begin
                    rst_state_next = RQ_DELAY;
                    rst_cnt_next   = '0;
                end
                RQ_DELAY: begin
                    rst_cnt_next = rst_cnt_reg + 1'b1;
                    if (rst_cnt_reg == CNT_W'(RST_DELAY_CYC - 1)) begin
                        rst_state_next = RQ_OSCSTART;
                        rst_cnt_next   = '0;
                    end
                end
                RQ_OSCSTART: begin
                    rst_cnt_next = rst_cnt_reg + 1'b1;
                    if (rst_cnt_reg == CNT_W'(OSC_START_CYC - 1)) begin
                        rst_state_next = RQ_OSCCAL;
                        rst_cnt_next   = '0;
                    end
                end
                RQ_OSCCAL: begin
                    rst_cnt_next = rst_cnt_reg + 1'b1;
                    if (rst_cnt_reg == CNT_W'(OSC_CAL_CYC - 1)) begin
                        rst_state_next = RQ_RUN;
                        rst_cnt_next   = '0;
                    end
                end
                RQ_RUN: rst_state_next = RQ_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_state_reg <= RQ_HOLD;
            rst_cnt_reg   <= '0;
        end else begin
            rst_state_reg <= rst_state_next;
            rst_cnt_reg   <= rst_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // reset status flags
    // ------------------------------------------------------------
    logic [NUM_RS-1:0] rst_flags_reg, rst_flags_next;
    logic [NUM_RS-1:0] flag_set;

    always_comb begin
        flag_set = {sw_rst_req_reg, src_sync_reg[4], src_sync_reg[3],
                    src_sync_reg[2], src_sync_reg[1], src_sync_reg[0]};
        rst_flags_next = rst_flags_reg | flag_set;
        if (src_sync_reg[RS_POR])
            rst_flags_next = NUM_RS'(1) << RS_POR;
    end

    // flags must survive non-power-on resets, so they see only presetn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rst_flags_reg <= '0;
        else
            rst_flags_reg <= rst_flags_next;
    end

    // ------------------------------------------------------------
    // software registers (sleep and power reduction cleared by system reset, not only presetn; boot_vec_reg by presetn only)
    // ------------------------------------------------------------
    logic       in_reset;
    logic [3:0] sleep_ctrl_reg, sleep_ctrl_next;
    logic [7:0] power_red_reg, power_red_next;
    logic       boot_vec_reg, boot_vec_next;
    logic       wr_en, rd_en;
    logic [31:0] prdata_next;

    assign in_reset = rst_state_reg != RQ_RUN;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    always_comb begin
        sleep_ctrl_next  = sleep_ctrl_reg;
        power_red_next   = power_red_reg;
        boot_vec_next    = boot_vec_reg;
        sw_rst_pend_next = 1'b0;
        if (in_reset) begin
            sleep_ctrl_next = SLEEP_CTRL_RST;
            power_red_next  = POWER_RED_RST;
        end else if (wr_en) begin
            unique case (paddr)
                SLEEP_CTRL_OFF: sleep_ctrl_next = pwdata[3:0];
                POWER_RED_OFF:  power_red_next  = pwdata[7:0];
                RESET_CTRL_OFF: begin
                    sw_rst_pend_next = pwdata[SW_RESET_BIT];
                    boot_vec_next    = pwdata[BOOT_VEC_BIT];
                end
                default: ;
            endcase
        end
        // issued on the following edge, cpu held meanwhile
        sw_rst_req_next = sw_rst_pend_reg;
    end

    always_comb begin
        prdata_next = '0;
        unique case (paddr)
            SLEEP_CTRL_OFF:   prdata_next = {28'h0000000, sleep_ctrl_reg};
            RESET_STATUS_OFF: prdata_next = {26'h0, rst_flags_reg};
            RESET_CTRL_OFF:   prdata_next = {30'h0, boot_vec_reg, 1'b0};
            POWER_RED_OFF:    prdata_next = {24'h000000, power_red_reg};
            STATE_OFF:        prdata_next = {29'h0, sleep_ctrl_reg[3:1]};
            default:          prdata_next = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_ctrl_reg  <= SLEEP_CTRL_RST;
            power_red_reg   <= POWER_RED_RST;
            boot_vec_reg    <= 1'b0;
            sw_rst_pend_reg <= 1'b0;
            sw_rst_req_reg  <= 1'b0;
            prdata          <= '0;
        end else begin
            sleep_ctrl_reg  <= sleep_ctrl_next;
            power_red_reg   <= power_red_next;
            boot_vec_reg    <= boot_vec_next;
            sw_rst_pend_reg <= sw_rst_pend_next;
            sw_rst_req_reg  <= sw_rst_req_next;
            if (rd_en)
                prdata <= prdata_next;
        end
    end

    // zero-wait slave; unmapped addresses read zero, those above STATE_OFF flag an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            pslverr <= psel & ~penable & (paddr > STATE_OFF);
        end
    end

    // ------------------------------------------------------------
    // sleep state machine
    // ------------------------------------------------------------
    typedef enum { SL_ACTIVE, SL_SLEEP, SL_WAKE } src_sleep_state_type;
    src_sleep_state_type sl_state_reg, sl_state_next;
    logic [2:0]          halt_cnt_reg, halt_cnt_next;
    src_sleep_mode_type  mode;
    logic                wake_hit;
    src_clk_gate_type    gate_next;

    assign mode = src_sleep_mode_type'(sleep_ctrl_reg[3:1]);

    // wake source allowed per mode; handler order is left to interrupt controller
    function automatic logic wake_allowed(src_sleep_mode_type m, logic [4:0] w);
        logic r;
        r = w[3] | w[2] | w[1];
        unique case (m)
            SM_IDLE:             r = w[4];
            SM_PSAVE, SM_ESTDBY: r = r | w[0];
            default:             r = r;
        endcase
        return r;
    endfunction

    always_comb begin
        sl_state_next = sl_state_reg;
        halt_cnt_next = halt_cnt_reg;
        wake_hit = wake_allowed(mode, wake_sync_reg);
        unique case (sl_state_reg)
            SL_ACTIVE:
                if (sleep_instr && sleep_ctrl_reg[SLEEP_EN_BIT])
                    sl_state_next = SL_SLEEP;
            SL_SLEEP:
                if (wake_hit) begin
                    sl_state_next = SL_WAKE;
                    halt_cnt_next = '0;
                end
            SL_WAKE: begin
                halt_cnt_next = halt_cnt_reg + 1'b1;
                if (halt_cnt_reg == 3'(WAKE_HALT_CYC - 1))
                    sl_state_next = SL_ACTIVE;
            end
        endcase
        if (in_reset)
            sl_state_next = SL_ACTIVE;

        // clock gates; state is held by stopping clocks, never clearing
        gate_next.cpu_clk_en    = sl_state_next == SL_ACTIVE && !in_reset;
        gate_next.nvm_clk_en    = sl_state_next == SL_ACTIVE;
        gate_next.periph_clk_en = sl_state_next != SL_SLEEP || mode == SM_IDLE;
        gate_next.rtc_clk_en    = sl_state_next != SL_SLEEP || mode == SM_IDLE ||
                                  mode == SM_PSAVE || mode == SM_ESTDBY;
        gate_next.sysosc_en     = sl_state_next != SL_SLEEP || mode == SM_IDLE ||
                                  mode == SM_STDBY || mode == SM_ESTDBY;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sl_state_reg       <= SL_ACTIVE;
            halt_cnt_reg       <= '0;
            clk_gate           <= '0;
            periph_clk_en      <= '0;
            cpu_halt           <= 1'b1;
            sys_rst_n          <= 1'b0;
            io_tristate        <= 1'b1;
            reset_vector       <= RESET_VECTOR_APP;
            clk_sel            <= CS_INTOSC2M;
            brownout_force_low <= 1'b0;
        end else begin
            sl_state_reg  <= sl_state_next;
            halt_cnt_reg  <= halt_cnt_next;
            clk_gate      <= gate_next;
            periph_clk_en <= gate_next.periph_clk_en ? ~power_red_next : 8'h00;
            cpu_halt      <= sl_state_next != SL_ACTIVE || in_reset || sw_rst_pend_next ||
                             sw_rst_pend_reg;
            sys_rst_n     <= ~any_req && !hw_req && rst_state_next == RQ_RUN;
            io_tristate   <= any_req || hw_req || in_reset;
            reset_vector  <= boot_vec_reg ? BOOT_VECTOR_DFLT : RESET_VECTOR_APP;
            if (in_reset)
                clk_sel <= CS_INTOSC2M;
            brownout_force_low <= ~brownout_en_cfg & (chip_erase | src_sync_reg[RS_DBG]);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_wake_start;
        sl_state_reg == SL_SLEEP && wake_hit && !in_reset;
    endsequence

    a_wake_halt_four: assert property (@(posedge pclk) disable iff (!presetn)
        s_wake_start |=> (sl_state_reg == SL_WAKE)[*4] ##1 sl_state_reg == SL_ACTIVE)
        else $error("wake halt not four cycles");
    a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
        sl_state_reg == SL_ACTIVE && !in_reset && !(sleep_instr && sleep_ctrl_reg[0])
        |=> sl_state_reg != SL_SLEEP)
        else $error("sleep entered without instruction");
    a_req_restart: assert property (@(posedge pclk) disable iff (!presetn)
        any_req |=> rst_state_reg == RQ_HOLD)
        else $error("release not restarted");
    a_release_order: assert property (@(posedge pclk) disable iff (!presetn)
        rst_state_reg == RQ_OSCCAL |-> $past(rst_state_reg) inside {RQ_OSCCAL, RQ_OSCSTART})
        else $error("release stage skipped");
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        !src_sync_reg[RS_POR] |=> (rst_flags_reg & $past(rst_flags_reg)) == $past(rst_flags_reg))
        else $error("reset flag lost");
    a_sw_reset_two: assert property (@(posedge pclk) disable iff (!presetn)
        sw_rst_pend_next |-> ##3 !sys_rst_n)
        else $error("software reset late");
    a_sys_rst_hold: assert property (@(posedge pclk) disable iff (!presetn)
        any_req |=> !sys_rst_n)
        else $error("reset released with request");
    a_clk_sel_2m: assert property (@(posedge pclk) disable iff (!presetn)
        in_reset |=> clk_sel == CS_INTOSC2M)
        else $error("clock not 2mhz after reset");
    a_pdown_gates: assert property (@(posedge pclk) disable iff (!presetn)
        sl_state_reg == SL_SLEEP && mode == SM_PDOWN |-> !clk_gate.rtc_clk_en &&
        !clk_gate.sysosc_en)
        else $error("clock running in power-down");
    a_io_tristate: assert property (@(posedge pclk) disable iff (!presetn)
        any_req |=> io_tristate)
        else $error("pins driven during reset");
    a_halt_sw_reset: assert property (@(posedge pclk) disable iff (!presetn)
        sw_rst_pend_next |=> cpu_halt)
        else $error("cpu ran before software reset");

endmodule : src_sleep_reset_ctrl

// ---- verif/src_far_model.sv ----
/* far side of the controller: cpu sleep pulse, wake sources, reset sources.
   assumes the bench drives its command inputs just after a rising pclk edge. */
`timescale 1ns/100ps
module src_far_model
    import src_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           sleep_go,
    input  wire logic           ext_low,
    input  wire logic           wdog_go,
    input  wire src_wake_type   wake_in,
    input  wire logic [1:0]     aux_rst,
    output src_rst_src_type     rst_src,
    output logic                sleep_instr,
    output src_wake_type        wake_src
);
    logic       sleep_d = 1'b0;
    logic       wd_d    = 1'b0;
    logic [5:0] wd_cnt  = 6'h00;
    initial sleep_instr = 1'b0;
    // ------------------------------------------------------------
    // one-cycle sleep pulse, watchdog pulse of two 2 MHz periods
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        sleep_instr <= sleep_go & ~sleep_d;
        sleep_d     <= sleep_go;
        wd_d        <= wdog_go;
        if (wdog_go & ~wd_d) begin
            wd_cnt <= 6'h28;
        end else if (wd_cnt != 6'h00) begin
            wd_cnt <= wd_cnt - 6'h01;
        end
    end
    // pin idles high through its pull-up when nobody pulls it
    // aux_rst[0] brownout level, aux_rst[1] debug interface level
    assign rst_src  = {1'b0, ~ext_low, aux_rst[0], wd_cnt != 6'h00, aux_rst[1]};
    assign wake_src = wake_in;
endmodule : src_far_model

// ---- verif/tb.sv ----
/* self-checking bench of the sleep and reset controller over apb.
   assumes the far side model drives reset, sleep and wake inputs. */
`timescale 1ns/100ps
module tb;
    import src_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h73F034A0;
    logic pready, pslverr, er, sleep_go = 1'b0, ext_low = 1'b0, wdog_go = 1'b0;
    logic chip_erase = 1'b0, cpu_halt, sys_rst_n, io_tristate, bfl;
    logic bcfg = 1'b0;
    logic [1:0] aux_rst = 2'b00;
    src_wake_type wake_in = '0, wake_src;
    src_rst_src_type rst_src;
    src_clk_gate_type clk_gate;
    src_clk_sel_type clk_sel;
    logic [7:0] periph_clk_en, pr;
    logic [17:0] reset_vector;
    logic sleep_instr;
    int miscompares = 0, total_checks = 0, n;
    int md[5] = '{0, 1, 2, 6, 7};
    logic [4:0] ge[5] = '{5'h07, 5'h00, 5'h02, 5'h01, 5'h03};
    logic [4:0] wk[5] = '{5'h10, 5'h02, 5'h01, 5'h04, 5'h08};
    initial forever #12.5 pclk = ~pclk;
    src_far_model far (.pclk(pclk), .sleep_go(sleep_go), .ext_low(ext_low), .wdog_go(wdog_go),
        .wake_in(wake_in), .aux_rst(aux_rst), .rst_src(rst_src), .sleep_instr(sleep_instr),
        .wake_src(wake_src));
    src_sleep_reset_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rst_src(rst_src), .chip_erase(chip_erase), .brownout_en_cfg(bcfg),
        .sleep_instr(sleep_instr), .wake_src(wake_src), .clk_gate(clk_gate),
        .periph_clk_en(periph_clk_en), .cpu_halt(cpu_halt), .sys_rst_n(sys_rst_n),
        .io_tristate(io_tristate), .reset_vector(reset_vector), .clk_sel(clk_sel),
        .brownout_force_low(bfl));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin miscompares++; wrap_up(); end
        rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wait_run(input int lim);
        for (n = 0; n < lim && sys_rst_n !== 1'b1; n++) @(posedge pclk);
        if (n == lim) begin miscompares++; wrap_up(); end
    endtask : wait_run
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(5);
        chk("tristate", 1, io_tristate);
        chk("clksel", CS_INTOSC2M, clk_sel);
        chk("vector", RESET_VECTOR_APP, reset_vector);
        presetn <= 1'b1;
        cyc(3000);
        chk("held", 0, sys_rst_n);
        wait_run(1000);
        apb(0, RESET_STATUS_OFF, 0);
        chk("status", 32'h1, rd & 32'h3F);
        apb(0, 8'h14, 0);
        chk("slverr", 1, er);
        lf = lfsr(lf); pr = lf[7:0];
        apb(1, POWER_RED_OFF, {24'h0, pr});
        cyc(2);
        chk("pr", {24'h0, ~pr}, periph_clk_en);
        for (int i = 0; i < 5; i++) begin
            apb(1, SLEEP_CTRL_OFF, (md[i] << 1) | 1);
            apb(0, STATE_OFF, 0);
            chk("mode", md[i], rd);
            sleep_go <= 1'b1; cyc(2); sleep_go <= 1'b0; cyc(3);
            chk("gate", ge[i], clk_gate);
            chk("prgate", md[i] == 0 ? {24'h0, ~pr} : 32'h0, periph_clk_en);
            chk("halt", 1, cpu_halt);
            if (md[i] == 1 || md[i] == 6) begin
                wake_in <= 5'h01; cyc(10);
                chk("nowake", 1, cpu_halt);
                wake_in <= '0; cyc(3);
            end
            wake_in <= wk[i];
            for (n = 0; n < 20 && cpu_halt !== 1'b0; n++) @(posedge pclk);
            wake_in <= '0;
            // two sync edges, one detect edge, four halted cycles, one sample edge
            chk("haltlen", 8, n);
            chk("cpuclk", 1, clk_gate.cpu_clk_en);
            apb(0, POWER_RED_OFF, 0);
            chk("kept", {24'h0, pr}, rd);
        end
        chip_erase <= 1'b1; cyc(4);
        chk("bodforce", 1, bfl);
        bcfg <= 1'b1; cyc(2);
        chk("bodcfg", 0, bfl);
        bcfg <= 1'b0;
        chip_erase <= 1'b0;
        apb(1, RESET_CTRL_OFF, 32'h2); cyc(2);
        chk("boot", BOOT_VECTOR_DFLT, reset_vector);
        apb(1, RESET_CTRL_OFF, 32'h1); cyc(3);
        chk("swrst", 0, sys_rst_n);
        wait_run(5000);
        aux_rst <= 2'b11; cyc(4);
        chk("auxrst", 0, sys_rst_n);
        chk("dbgforce", 1, bfl);
        aux_rst <= 2'b00;
        wait_run(5000);
        ext_low <= 1'b1; cyc(4);
        chk("extrst", 0, sys_rst_n);
        cyc(50);
        chk("exthold", 0, sys_rst_n);
        ext_low <= 1'b0; cyc(2000);
        wdog_go <= 1'b1; cyc(2); wdog_go <= 1'b0; cyc(3000);
        chk("restart", 0, sys_rst_n);
        wait_run(2000);
        apb(0, RESET_STATUS_OFF, 0);
        chk("flags", 32'h3F, rd & 32'h3F);
        wrap_up();
    end
endmodule : tb
